// file: core/vga_map_pkg.sv
// constants for the frame address mapper and its register slave
package vga_map_pkg;
    // ***********************************************
    // register map (byte addresses)
    // ***********************************************
    localparam int ADDR_W = 4;
    localparam logic [3:0] OFF_UNDERLINE = 4'h0;
    localparam logic [3:0] OFF_MODE_CTRL = 4'h4;
    localparam logic [3:0] OFF_MAPPED = 4'h8;
    // ***********************************************
    // field positions
    // ***********************************************
    localparam int UL_DWORD_BIT = 6;
    localparam int MODE_COMPAT_BIT = 0;
    localparam int MODE_ROWSCAN_BIT = 1;
    localparam int MODE_WRAP_BIT = 5;
    localparam int MODE_BYTEWORD_BIT = 6;
    // ***********************************************
    // reset values: byte mode, no substitution
    // ***********************************************
    localparam logic [7:0] UNDERLINE_RST = 8'h00;
    localparam logic [7:0] MODE_CTRL_RST = 8'h43;
    localparam logic [7:0] UNDERLINE_MASK = 8'h40;
    localparam logic [7:0] MODE_CTRL_MASK = 8'h63;
    // ***********************************************
    // bus answers
    // ***********************************************
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// file: core/frame_addr_reorder.sv
// combinational reorder and row-scan substitution of the counter address
`timescale 1ns/1ps
module frame_addr_reorder (
    // counters
    input wire logic [15:0] addr_count,
    input wire logic [1:0] row_scan_bit,
    // mode selects
    input wire logic dword_sel,
    input wire logic byte_word_sel,
    input wire logic wrap_sel,
    input wire logic compat_sel,
    input wire logic row_scan_sel,
    // results
    output logic [15:0] reordered_addr_bit,
    output logic [15:0] decoder_addr_input
);
    // ***********************************************
    // addressing mode reorder
    // ***********************************************
    logic [15:0] word_addr;
    logic [15:0] dword_addr;
    assign word_addr = {addr_count[14:0], wrap_sel ? addr_count[15] : addr_count[13]};
    assign dword_addr = {addr_count[13:0], addr_count[13:12]};
    assign reordered_addr_bit = dword_sel ? dword_addr
                              : (byte_word_sel ? addr_count : word_addr);
    // ***********************************************
    // row-scan substitution, after the reorder
    // ***********************************************
    // substitute after reorder
    assign decoder_addr_input[12:0] = reordered_addr_bit[12:0];
    assign decoder_addr_input[15] = reordered_addr_bit[15];
    assign decoder_addr_input[13] = compat_sel ? reordered_addr_bit[13] : row_scan_bit[0];
    assign decoder_addr_input[14] = row_scan_sel ? reordered_addr_bit[14] : row_scan_bit[1];
endmodule // frame_addr_reorder

// file: core/vga_frame_address_mapper.sv
// frame address mapper with its mode registers on an axi4-lite slave
// Contract
// - reorder first, then substitute, then drive
// - byte mode passes all sixteen bits
// - word wrap high: bit0 from bit 15
// - word wrap low: bit0 from bit 13
// - dword: bits 12,13 low, shift two
// - only bits 13 and 14 replaced
// - other decoder bits equal reordered bits
// - compat select 0 puts row scan 0
// - row-scan select 0 puts row scan 1
`timescale 1ns/1ps
module vga_frame_address_mapper (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // write address and data
    input wire logic awvalid,
    output logic awready,
    input wire logic [vga_map_pkg::ADDR_W-1:0] awaddr,
    input wire logic [2:0] awprot,
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    // write response
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // read address
    input wire logic arvalid,
    output logic arready,
    input wire logic [vga_map_pkg::ADDR_W-1:0] araddr,
    input wire logic [2:0] arprot,
    // read data
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    // character-clocked counters
    input wire logic [15:0] addr_count,
    input wire logic [1:0] row_scan_bit,
    // to the frame buffer decoder
    output logic [15:0] decoder_addr_input
);
    // ***********************************************
    // mode registers
    // ***********************************************
    logic [7:0] underline_location_reg;
    logic [7:0] crtc_mode_control_reg;
    logic [15:0] reordered_addr_bit;
    wire dword_sel = underline_location_reg[vga_map_pkg::UL_DWORD_BIT];
    wire byte_word_sel = crtc_mode_control_reg[vga_map_pkg::MODE_BYTEWORD_BIT];
    wire wrap_sel = crtc_mode_control_reg[vga_map_pkg::MODE_WRAP_BIT];
    wire compat_sel = crtc_mode_control_reg[vga_map_pkg::MODE_COMPAT_BIT];
    wire row_scan_sel = crtc_mode_control_reg[vga_map_pkg::MODE_ROWSCAN_BIT];

    // ***********************************************
    // write channel
    // ***********************************************
    // both address and data must be present; one write in flight
    wire wr_take = awvalid && wvalid && !awready && !bvalid;
    wire wr_ul = awaddr == vga_map_pkg::OFF_UNDERLINE;
    wire wr_mode = awaddr == vga_map_pkg::OFF_MODE_CTRL;
    wire wr_lane0 = wstrb[0];
    // unused field bits forced to zero so reads show only live selects
    wire [7:0] next_underline = wdata[7:0] & vga_map_pkg::UNDERLINE_MASK;
    wire [7:0] next_mode = wdata[7:0] & vga_map_pkg::MODE_CTRL_MASK;
    wire [1:0] next_bresp = (wr_ul || wr_mode) ? vga_map_pkg::RESP_OKAY
                                               : vga_map_pkg::RESP_SLVERR;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready <= 1'b0;
            wready <= 1'b0;
            bvalid <= 1'b0;
            bresp <= vga_map_pkg::RESP_OKAY;
        end else begin
            awready <= wr_take;
            wready <= wr_take;
            if (wr_take) begin
                bvalid <= 1'b1;
                bresp <= next_bresp;
            end else if (bready) begin
                bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            underline_location_reg <= vga_map_pkg::UNDERLINE_RST;
            crtc_mode_control_reg <= vga_map_pkg::MODE_CTRL_RST;
        end else if (wr_take && wr_lane0) begin
            if (wr_ul) begin
                underline_location_reg <= next_underline;
            end
            if (wr_mode) begin
                crtc_mode_control_reg <= next_mode;
            end
        end
    end

    // ***********************************************
    // read channel
    // ***********************************************
    wire rd_take = arvalid && !arready && !rvalid;
    wire rd_ul = araddr == vga_map_pkg::OFF_UNDERLINE;
    wire rd_mode = araddr == vga_map_pkg::OFF_MODE_CTRL;
    wire rd_mapped = araddr == vga_map_pkg::OFF_MAPPED;
    wire rd_hit = rd_ul || rd_mode || rd_mapped;
    // the mapped word is the live decoder value at the take edge
    wire [31:0] next_rdata = rd_ul ? {24'h000000, underline_location_reg}
                           : rd_mode ? {24'h000000, crtc_mode_control_reg}
                           : rd_mapped ? {16'h0000, decoder_addr_input}
                           : 32'h00000000;
    wire [1:0] next_rresp = rd_hit ? vga_map_pkg::RESP_OKAY : vga_map_pkg::RESP_SLVERR;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b0;
            rvalid <= 1'b0;
            rdata <= 32'h00000000;
            rresp <= vga_map_pkg::RESP_OKAY;
        end else begin
            arready <= rd_take;
            if (rd_take) begin
                rvalid <= 1'b1;
                rdata <= next_rdata;
                rresp <= next_rresp;
            end else if (rready) begin
                rvalid <= 1'b0;
            end
        end
    end

    // ***********************************************
    // address path
    // ***********************************************
    // decoder output is left unregistered so the mapped address
    // lands in the same cycle as the counter value
    // same-cycle mapping
    frame_addr_reorder u_reorder (
        .addr_count(addr_count),
        .row_scan_bit(row_scan_bit),
        .dword_sel(dword_sel),
        .byte_word_sel(byte_word_sel),
        .wrap_sel(wrap_sel),
        .compat_sel(compat_sel),
        .row_scan_sel(row_scan_sel),
        .reordered_addr_bit(reordered_addr_bit),
        .decoder_addr_input(decoder_addr_input)
    );

    // ***********************************************
    // checks
    // ***********************************************
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    wire byte_mode = !dword_sel && byte_word_sel;
    wire word_mode = !dword_sel && !byte_word_sel;

    a_byte_pass: assert property (byte_mode |-> reordered_addr_bit == addr_count)
        else $error("byte mode altered the address");
    a_word_wrap_hi: assert property ((word_mode && wrap_sel) |->
        reordered_addr_bit == {addr_count[14:0], addr_count[15]})
        else $error("word mode wrap high misordered");
    a_word_wrap_lo: assert property ((word_mode && !wrap_sel) |->
        reordered_addr_bit == {addr_count[14:0], addr_count[13]})
        else $error("word mode wrap low misordered");
    a_dword_order: assert property (dword_sel |->
        reordered_addr_bit[1:0] == addr_count[13:12]
        && reordered_addr_bit[15:2] == addr_count[13:0])
        else $error("dword mode misordered");
    a_fixed_bits: assert property (decoder_addr_input[12:0] == reordered_addr_bit[12:0]
        && decoder_addr_input[15] == reordered_addr_bit[15])
        else $error("unsubstituted decoder bit differs");
    a_compat_subst: assert property (decoder_addr_input[13] ==
        (compat_sel ? reordered_addr_bit[13] : row_scan_bit[0]))
        else $error("decoder bit 13 wrong");
    a_rowscan_subst: assert property (decoder_addr_input[14] ==
        (row_scan_sel ? reordered_addr_bit[14] : row_scan_bit[1]))
        else $error("decoder bit 14 wrong");
    a_only_two_bits: assert property ((decoder_addr_input ^ reordered_addr_bit)
        == ((decoder_addr_input ^ reordered_addr_bit) & 16'h6000))
        else $error("substitution outside bits 13 and 14");
    a_same_cycle: assert property (($changed(addr_count) && $stable(underline_location_reg)
        && $stable(crtc_mode_control_reg) && byte_mode && compat_sel && row_scan_sel)
        |-> decoder_addr_input == addr_count)
        else $error("decoder address lags the counter");

    sequence s_mode_write;
        wr_take && wr_lane0 && wr_mode;
    endsequence
    a_mode_applied: assert property (s_mode_write |=>
        crtc_mode_control_reg == $past(next_mode) ##0
        (compat_sel || decoder_addr_input[13] == row_scan_bit[0]))
        else $error("mode write not applied to mapping");

    // ***********************************************
    // bus handshake checks
    // ***********************************************
    // handshake checks assume one write and one read in flight
    sequence s_wr_answer;
        awready && wready && bvalid && bresp == $past(next_bresp);
    endsequence
    sequence s_rd_answer;
        arready && rvalid && rdata == $past(next_rdata) && rresp == $past(next_rresp);
    endsequence
    a_wr_answer: assert property (wr_take |=> s_wr_answer)
        else $error("write take not answered next cycle");
    a_rd_answer: assert property (rd_take |=> s_rd_answer)
        else $error("read take not answered next cycle");
    a_ready_pulse: assert property ((awready || arready) |=> !awready && !arready)
        else $error("ready held longer than one cycle");
    // release after acceptance frees the slave for the next take
    a_bvalid_release: assert property ((bvalid && bready) |=> !bvalid)
        else $error("write response not released");
    a_rvalid_release: assert property ((rvalid && rready) |=> !rvalid)
        else $error("read response not released");
endmodule // vga_frame_address_mapper

// file: tb/vga_frame_address_mapper_tb_top.sv
// self-checking bench for the frame address mapper and its register slave
`timescale 1ns/1ps
module vga_frame_address_mapper_tb_top;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid;
    logic [vga_map_pkg::ADDR_W-1:0] awaddr, araddr;
    logic [3:0] wstrb;
    logic [31:0] wdata, rdata;
    logic [1:0] bresp, rresp, row_scan_bit;
    logic [15:0] addr_count, decoder_addr_input;
    int n_errors, compares;
    typedef struct packed {logic [7:0] ul; logic [7:0] md; logic [15:0] a; logic [1:0] r;
                           logic [15:0] e;} row_t;
    // byte, word wrap 1/0, dword, then the substitution selects; expected decoder last
    row_t rows [8] = '{
        '{8'h00, 8'h43, 16'hA5C3, 2'h2, 16'hA5C3},
        '{8'h00, 8'h23, 16'h8001, 2'h0, 16'h0003},
        '{8'h00, 8'h03, 16'h2001, 2'h0, 16'h4003},
        '{8'h40, 8'h63, 16'h3001, 2'h0, 16'hC007},
        '{8'h00, 8'h40, 16'hFFFF, 2'h0, 16'h9FFF},
        '{8'h00, 8'h41, 16'h0000, 2'h3, 16'h4000},
        '{8'h00, 8'h42, 16'h0000, 2'h3, 16'h2000},
        '{8'h40, 8'h00, 16'h1234, 2'h1, 16'h28D1}};
    vga_frame_address_mapper i_dut (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
        .awready(awready), .awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid), .wready(wready),
        .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp),
        .arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(3'h0),
        .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
        .addr_count(addr_count), .row_scan_bit(row_scan_bit),
        .decoder_addr_input(decoder_addr_input));
    initial begin
        aclk = 1'h0;
        forever #12.5 aclk = ~aclk;
    end
    task automatic wrap_up;
        $display("compares %0d errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic chk_bus(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk_addr(input string nm, input logic [15:0] e);
        compares++;
        if (decoder_addr_input !== e) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", nm, e, decoder_addr_input);
        end
    endtask
    task automatic axi_wr(input logic [3:0] a, input logic [7:0] d, input logic [3:0] s,
                          input logic [1:0] er);
        int i;
        @(posedge aclk);
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        awaddr <= a;
        wdata <= {24'hFFFF00, d};
        wstrb <= s;
        bready <= 1'h1;
        for (i = 0; i < 20; i++) begin
            @(posedge aclk);
            if (awready) awvalid <= 1'h0;
            if (wready) wvalid <= 1'h0;
            if (bvalid) break;
        end
        bready <= 1'h0;
        if (i == 20) begin
            n_errors++;
            wrap_up();
        end
        chk_bus("bresp", {30'h0, er}, {30'h0, bresp});
    endtask
    task automatic axi_rd(input logic [3:0] a, input logic [31:0] e, input logic [1:0] er);
        int i;
        @(posedge aclk);
        arvalid <= 1'h1;
        araddr <= a;
        rready <= 1'h1;
        for (i = 0; i < 20; i++) begin
            @(posedge aclk);
            if (arready) arvalid <= 1'h0;
            if (rvalid) break;
        end
        rready <= 1'h0;
        if (i == 20) begin
            n_errors++;
            wrap_up();
        end
        chk_bus("rdata", e, rdata);
        chk_bus("rresp", {30'h0, er}, {30'h0, rresp});
    endtask
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
        {awaddr, araddr, wstrb, wdata} = '0;
        addr_count = 16'hBEEF;
        row_scan_bit = 2'h3;
        repeat (6) @(posedge aclk);
        aresetn <= 1'h1;
        foreach (rows[k]) begin
            axi_wr(vga_map_pkg::OFF_UNDERLINE, rows[k].ul, 4'hF, vga_map_pkg::RESP_OKAY);
            axi_wr(vga_map_pkg::OFF_MODE_CTRL, rows[k].md, 4'hF, vga_map_pkg::RESP_OKAY);
            @(posedge aclk);
            addr_count <= rows[k].a;
            row_scan_bit <= rows[k].r;
            @(negedge aclk);
            chk_addr("decoder", rows[k].e);
            axi_rd(vga_map_pkg::OFF_MAPPED, {16'h0, rows[k].e}, 2'h0);
        end
        // read-only, unmapped and strobe-less accesses leave the mode alone
        axi_rd(vga_map_pkg::OFF_MODE_CTRL, 32'h00, vga_map_pkg::RESP_OKAY);
        axi_wr(vga_map_pkg::OFF_MAPPED, 8'h43, 4'hF, vga_map_pkg::RESP_SLVERR);
        axi_wr(4'hC, 8'h43, 4'hF, vga_map_pkg::RESP_SLVERR);
        axi_wr(vga_map_pkg::OFF_MODE_CTRL, 8'h43, 4'h0, vga_map_pkg::RESP_OKAY);
        axi_rd(4'hC, 32'h0, vga_map_pkg::RESP_SLVERR);
        axi_rd(vga_map_pkg::OFF_MODE_CTRL, 32'h00, vga_map_pkg::RESP_OKAY);
        @(negedge aclk);
        chk_addr("no_change", rows[7].e);
        // mid-run reset returns byte mode without substitution
        @(posedge aclk);
        aresetn <= 1'h0;
        repeat (6) @(posedge aclk);
        aresetn <= 1'h1;
        axi_rd(vga_map_pkg::OFF_UNDERLINE, 32'h00, vga_map_pkg::RESP_OKAY);
        axi_rd(vga_map_pkg::OFF_MODE_CTRL, 32'h43, vga_map_pkg::RESP_OKAY);
        @(negedge aclk);
        chk_addr("after_reset", addr_count);
        wrap_up();
    end
endmodule // vga_frame_address_mapper_tb_top
